// *** rtl/irq_nest_ctrl.sv ***
// Interrupt acceptance, nesting status, shared vector and standby control.
//
// How it works
// (RULE1) Status bits sit at word bits 3,2.
// (RULE2) High source accepted in status 0 or 1.
// (RULE3) Status 0 accepts all, goes to 01.
// (RULE4) Status 1 accepts high only, goes 10.
// (RULE5) Status 2 accepts nothing.
// (RULE6) Code 11 never held nor written.
// (RULE7) Status pushed on accept, restored on return.
// (RULE8) Software writing 00 reopens all nesting.
// (RULE9) Software disables interrupts before editing status.
// (RULE10) Timer and pin 4 share one slot.
// (RULE11) One enabled shared source behaves as unshared.
// (RULE12) Both enabled: either flag raises request.
// (RULE13) Both enabled: accept clears neither flag.
// (RULE14) Shared handler tests and clears each flag.
// (RULE15) Deep stop only on main clock.
// (RULE16) Stop halts main clock; halt gates CPU.
// (RULE17) Pin 0 dead in standby; 1,2,4 live.
// (RULE18) Enabled request or reset ends standby.
// (RULE19) Timer stops in deep stop, runs in halt.
// (RULE20) Flag and enable together raise a request.
// (RULE21) Priority low bits select; bit 3 masters.
// (RULE22) Fixed order, one vector per acceptance.
`timescale 1ns/10ps
module irq_nest_ctrl
  import irq_nest_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [DATA_W-1:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [DATA_W-1:0] HRDATA,
  // Source events, one-cycle pulses.
  input wire logic [NSRC-1:0] SRC_EVENT,
  input wire logic CPU_ON_SUBCLK,
  // CPU sequencer.
  output logic VEC_VALID,
  output logic [SLOT_W-1:0] VEC_SLOT,
  input wire logic VEC_TAKE,
  output logic [3:0] PROGRAM_STATUS_WORD,
  input wire logic RETURN_FROM_IRQ,
  input wire logic [3:0] RETURN_STATUS_WORD,
  output logic ANY_REQUEST,
  // Clock control.
  output logic CPU_CLK_STOP,
  output logic MAIN_CLK_STOP
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [NSRC-1:0] flags_q;
  logic [NSRC-1:0] flags_d;
  logic [NSRC-1:0] enables_q;
  logic [3:0] prio_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  standby_mode_t mode_q;
  ahb_phase_t aphase_q;
  logic [DATA_W-1:0] rdata_q;
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] take_clr;
  logic [NSRC-1:0] read_clr;
  logic [NSLOT-1:0] slot_req;
  logic both_shared;
  logic addr_take;
  logic wr_now;
  logic take;
  vector_offer_t offer;

  // Maps a vector slot to the flags that its acceptance clears.
  function automatic logic [NSRC-1:0] slot_clear(
    input logic [SLOT_W-1:0] slot,
    input logic [NSRC-1:0] en
  );
    logic [NSRC-1:0] m;
    m = '0;
    if (slot == SLOT_SHARED) begin // RULE13
      if (en[SRC_TIMER] && !en[SRC_PIN4]) begin
        m[SRC_TIMER] = 1'b1; // RULE11
      end else if (en[SRC_PIN4] && !en[SRC_TIMER]) begin
        m[SRC_PIN4] = 1'b1; // RULE11
      end
    end else begin
      m[int'(slot) + 1] = 1'b1; // RULE20
    end
    return m;
  endfunction : slot_clear

  // ==========================================================================
  // AHB-Lite slave
  // ==========================================================================
  // Zero wait states: the address phase is captured and the write lands in
  // the data phase, while read data is latched from the address phase.
  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;
  assign wr_now = aphase_q.valid && aphase_q.write;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aphase_q <= '0;
    end else if (HREADY) begin
      aphase_q.valid <= addr_take;
      aphase_q.write <= HWRITE;
      aphase_q.addr <= {HADDR[7:2], 2'b00};
    end
  end

  // Read data; unmapped addresses read as zero.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= '0;
    end else if (addr_take && !HWRITE) begin
      unique case ({HADDR[7:2], 2'b00})
        OFS_REQ_FLAGS, OFS_TEST_CLEAR: rdata_q <= DATA_W'(flags_q);
        OFS_ENABLES: rdata_q <= DATA_W'(enables_q);
        OFS_PRIORITY: rdata_q <= DATA_W'(prio_q);
        OFS_PROC_STATUS: rdata_q <= DATA_W'(PROGRAM_STATUS_WORD);
        OFS_STANDBY: rdata_q <= DATA_W'({mode_q == SB_STOP,
                                         mode_q == SB_HALT});
        default: rdata_q <= '0;
      endcase
    end
  end

  // Reading the test-and-clear word clears exactly the flags it returned.
  assign read_clr = (addr_take && !HWRITE &&
                     {HADDR[7:2], 2'b00} == OFS_TEST_CLEAR) ?
                    flags_q : '0; // RULE14

  // ==========================================================================
  // Request flags
  // ==========================================================================
  // Pin 0 is sampled by the CPU clock, so it is dead in any standby; the
  // timer is frozen only in deep stop and keeps ticking in halt.
  always_comb begin
    hw_set = SRC_EVENT;
    if (mode_q != SB_RUN) begin
      hw_set[SRC_PIN0] = 1'b0; // RULE17
    end
    if (mode_q == SB_STOP) begin
      hw_set[SRC_TIMER] = 1'b0; // RULE19
    end
  end

  assign take = VEC_TAKE && VEC_VALID;
  assign take_clr = take ? slot_clear(VEC_SLOT, enables_q) : '0;

  // A hardware set in the same cycle as any clear wins.
  always_comb begin
    flags_d = flags_q;
    if (wr_now && aphase_q.addr == OFS_REQ_FLAGS) begin
      flags_d = HWDATA[NSRC-1:0];
    end
    flags_d = (flags_d & ~take_clr & ~read_clr) | hw_set;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_q <= RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================================
  // Enables and priority select
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      enables_q <= RST_ENABLES;
    end else if (wr_now && aphase_q.addr == OFS_ENABLES) begin
      enables_q <= HWDATA[NSRC-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prio_q <= RST_PRIORITY; // RULE21
    end else if (wr_now && aphase_q.addr == OFS_PRIORITY) begin
      prio_q <= HWDATA[3:0];
    end
  end

  // ==========================================================================
  // Slot requests and selection
  // ==========================================================================
  // The shared slot is raised by either enabled flag, since the handler
  // sorts the source out itself.
  assign both_shared = enables_q[SRC_TIMER] && enables_q[SRC_PIN4];
  always_comb begin
    slot_req[SLOT_SHARED] = (flags_q[SRC_TIMER] && enables_q[SRC_TIMER]) ||
                            (flags_q[SRC_PIN4] &&
                             enables_q[SRC_PIN4]); // RULE10 RULE12
    for (int s = 1; s < NSLOT; s++) begin
      slot_req[s] = flags_q[s + 1] && enables_q[s + 1]; // RULE20
    end
  end

  // Any enabled request, also used to wake from standby.
  assign ANY_REQUEST = |slot_req;

  vector_pick u_pick (
    .req(slot_req),
    .high_sel(prio_q[2:0]),
    .status(status_q),
    .master_en(prio_q[PRI_MASTER_BIT] && mode_q == SB_RUN), // RULE21
    .offer(offer)
  );

  // One vector at a time; the CPU does not run during standby.
  assign VEC_VALID = offer.valid; // RULE22 RULE2
  assign VEC_SLOT = offer.slot;

  // ==========================================================================
  // Processing status
  // ==========================================================================
  // Acceptance steps up one level, return restores the stacked bits, and a
  // bus write may drop the level; code 11 is never stored.
  always_comb begin
    status_d = status_q;
    if (take) begin
      unique case (status_q)
        ST_NORMAL: status_d = ST_ONE; // RULE3
        ST_ONE: status_d = ST_TWO; // RULE4
        default: status_d = status_q;
      endcase
    end else if (RETURN_FROM_IRQ) begin
      if (RETURN_STATUS_WORD[STATUS_HI_BIT:STATUS_LO_BIT] != ST_BAD) begin
        status_d = RETURN_STATUS_WORD[STATUS_HI_BIT:STATUS_LO_BIT]; // RULE7
      end
    end else if (wr_now && aphase_q.addr == OFS_PROC_STATUS) begin
      if (HWDATA[STATUS_HI_BIT:STATUS_LO_BIT] != ST_BAD) begin
        status_d = HWDATA[STATUS_HI_BIT:STATUS_LO_BIT]; // RULE8 RULE6
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_q <= ST_NORMAL;
    end else begin
      status_q <= status_d;
    end
  end

  // The sequencer stacks this word at acceptance.
  assign PROGRAM_STATUS_WORD = {status_q, 2'b00}; // RULE1 RULE7

  // ==========================================================================
  // Standby control
  // ==========================================================================
  // Deep stop is refused while the subsystem clock drives the CPU; a wake
  // has priority so a pending request leaves standby at once.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= SB_RUN;
    end else if (mode_q != SB_RUN && ANY_REQUEST) begin
      mode_q <= SB_RUN; // RULE18
    end else if (wr_now && aphase_q.addr == OFS_STANDBY &&
                 mode_q == SB_RUN) begin
      if (HWDATA[SB_STOP_BIT] && !CPU_ON_SUBCLK) begin
        mode_q <= SB_STOP; // RULE15
      end else if (HWDATA[SB_HALT_BIT]) begin
        mode_q <= SB_HALT; // RULE15
      end
    end
  end

  assign CPU_CLK_STOP = (mode_q != SB_RUN); // RULE16
  assign MAIN_CLK_STOP = (mode_q == SB_STOP); // RULE16

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence take_in_normal_s;
    take && status_q == ST_NORMAL;
  endsequence

  sequence take_in_one_s;
    take && status_q == ST_ONE;
  endsequence

  status_legal_a: assert property (status_q != ST_BAD) // RULE6
    else $error("processing status holds code 11");

  normal_step_a: assert property ( // RULE3
    take_in_normal_s |=> status_q == ST_ONE)
    else $error("acceptance in status 0 did not move to 01");

  one_step_a: assert property (take_in_one_s |=> status_q == ST_TWO) // RULE4
    else $error("acceptance in status 1 did not move to 10");

  two_blocks_a: assert property (status_q == ST_TWO |-> !VEC_VALID) // RULE5
    else $error("vector offered in status 2");

  one_high_only_a: assert property ( // RULE2
    status_q == ST_ONE && VEC_VALID |-> VEC_SLOT == {1'b0, prio_q[2:0]})
    else $error("non-high vector offered in status 1");

  master_gate_a: assert property ( // RULE21
    !prio_q[PRI_MASTER_BIT] |-> !VEC_VALID)
    else $error("vector offered with master enable clear");

  return_restore_a: assert property ( // RULE7
    RETURN_FROM_IRQ && !take && RETURN_STATUS_WORD[3:2] != ST_BAD
    |=> status_q == $past(RETURN_STATUS_WORD[3:2]))
    else $error("return did not restore stacked status");

  shared_keep_a: assert property ( // RULE13
    take && VEC_SLOT == SLOT_SHARED && both_shared && flags_q[SRC_PIN4] &&
    read_clr == '0 && !wr_now |=> flags_q[SRC_PIN4])
    else $error("shared acceptance cleared a flag");

  wake_up_a: assert property ( // RULE18
    mode_q != SB_RUN && ANY_REQUEST |=> mode_q == SB_RUN && !CPU_CLK_STOP)
    else $error("enabled request did not end standby");

  stop_refused_a: assert property ( // RULE15
    mode_q == SB_RUN && CPU_ON_SUBCLK |=> mode_q != SB_STOP)
    else $error("deep stop entered on subsystem clock");

  timer_frozen_a: assert property ( // RULE19
    mode_q == SB_STOP && !flags_q[SRC_TIMER] && !wr_now
    |=> !flags_q[SRC_TIMER] || mode_q != SB_STOP || $past(ANY_REQUEST))
    else $error("timer flag set during deep stop");

  event_sets_a: assert property ( // RULE20
    hw_set[SRC_PIN1] |=> flags_q[SRC_PIN1])
    else $error("pin 1 event did not set its flag");

endmodule : irq_nest_ctrl

// *** rtl/irq_nest_pkg.sv ***
// Shared constants and types of the nested interrupt status controller.
package irq_nest_pkg;

  // ==========================================================================
  // Sources, vector slots and bus geometry
  // ==========================================================================
  localparam int NSRC = 10;
  localparam int NSLOT = 9;
  localparam int SLOT_W = 4;
  localparam int DATA_W = 32;

  // Source numbering of the request and enable flags.
  localparam int SRC_TIMER = 0;
  localparam int SRC_PIN4 = 1;
  localparam int SRC_PIN0 = 2;
  localparam int SRC_PIN1 = 3;
  localparam int SRC_PIN2 = 4;
  // Slot 0 is the shared slot; slot n (n > 0) serves source n + 1.
  localparam logic [SLOT_W-1:0] SLOT_SHARED = 4'h0;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_REQ_FLAGS = 8'h00;
  localparam logic [7:0] OFS_TEST_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLES = 8'h08;
  localparam logic [7:0] OFS_PRIORITY = 8'h0C;
  localparam logic [7:0] OFS_PROC_STATUS = 8'h10;
  localparam logic [7:0] OFS_STANDBY = 8'h14;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int PRI_MASTER_BIT = 3;
  localparam int STATUS_HI_BIT = 3;
  localparam int STATUS_LO_BIT = 2;
  localparam int SB_HALT_BIT = 0;
  localparam int SB_STOP_BIT = 1;
  localparam logic [NSRC-1:0] RST_FLAGS = 10'h000;
  localparam logic [NSRC-1:0] RST_ENABLES = 10'h000;
  localparam logic [3:0] RST_PRIORITY = 4'h0;

  // Processing status codes; code 11 is never held.
  localparam logic [1:0] ST_NORMAL = 2'h0;
  localparam logic [1:0] ST_ONE = 2'h1;
  localparam logic [1:0] ST_TWO = 2'h2;
  localparam logic [1:0] ST_BAD = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {SB_RUN, SB_HALT, SB_STOP} standby_mode_t;

  // Captured AHB address phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_phase_t;

  // Vector offered to the CPU sequencer.
  typedef struct packed {
    logic valid;
    logic [SLOT_W-1:0] slot;
  } vector_offer_t;

endpackage : irq_nest_pkg

// *** rtl/vector_pick.sv ***
// Picks the one vector slot that may be accepted in the current status.
`timescale 1ns/10ps
module vector_pick
  import irq_nest_pkg::*;
(
  input wire logic [NSLOT-1:0] req,
  input wire logic [2:0] high_sel,
  input wire logic [1:0] status,
  input wire logic master_en,
  output vector_offer_t offer
);

  logic [NSLOT-1:0] high_mask;
  logic [NSLOT-1:0] eligible;

  // Only the slot named by the priority select counts as high priority.
  always_comb begin
    high_mask = '0;
    high_mask[high_sel] = 1'b1;
  end

  // Status gates what may be taken at all.
  always_comb begin
    eligible = '0;
    if (master_en) begin
      unique case (status)
        ST_NORMAL: eligible = req; // RULE3
        ST_ONE: eligible = req & high_mask; // RULE2 RULE4
        ST_TWO: eligible = '0; // RULE5
        default: eligible = '0;
      endcase
    end
  end

  // The high slot wins; otherwise the lowest slot number wins.
  always_comb begin
    offer.valid = |eligible;
    offer.slot = '0;
    if (|(eligible & high_mask)) begin
      offer.slot = {1'b0, high_sel};
    end else begin
      for (int i = NSLOT - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          offer.slot = SLOT_W'(i); // RULE22
        end
      end
    end
  end

endmodule : vector_pick

// *** dv/cpu_seq_model.sv ***
// Behavioural model of the CPU sequencer that takes vectors and returns.
`timescale 1ns/10ps
module cpu_seq_model (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic VEC_VALID,
  input wire logic [3:0] VEC_SLOT,
  input wire logic [3:0] PROGRAM_STATUS_WORD,
  input wire logic take_en,
  input wire logic ret_req,
  output logic VEC_TAKE,
  output logic RETURN_FROM_IRQ,
  output logic [3:0] RETURN_STATUS_WORD,
  output logic [3:0] last_slot
);
  logic [3:0] stack_q[$];
  logic take_now;

  assign take_now = take_en && VEC_VALID && !VEC_TAKE;

  // ==========================================================================
  // Stacking and return
  // ==========================================================================
  // The status word is stacked before the take edge moves it up a level.
  // The return word does not hold its value outside the return pulse.
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      VEC_TAKE <= 1'b0;
      RETURN_FROM_IRQ <= 1'b0;
      RETURN_STATUS_WORD <= 4'h0;
      last_slot <= 4'h0;
      stack_q.delete();
    end else begin
      VEC_TAKE <= take_now;
      if (take_now) begin
        stack_q.push_back(PROGRAM_STATUS_WORD);
        last_slot <= VEC_SLOT;
      end
      RETURN_FROM_IRQ <= ret_req;
      if (ret_req && stack_q.size() > 0) begin
        RETURN_STATUS_WORD <= stack_q.pop_back();
      end else begin
        RETURN_STATUS_WORD <= ~RETURN_STATUS_WORD;
      end
    end
  end
endmodule : cpu_seq_model

// *** dv/nested_interrupt_status_control_tb.sv ***
// Self-checking bench of the nested interrupt status controller.
`timescale 1ns/10ps
module nested_interrupt_status_control_tb;
  import irq_nest_pkg::*;
  logic CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic HREADY, HREADYOUT, HRESP, VEC_VALID, VEC_TAKE, ANY_REQUEST;
  logic RETURN_FROM_IRQ;
  logic [31:0] HRDATA;
  logic [NSRC-1:0] SRC_EVENT = '0;
  logic CPU_ON_SUBCLK = 1'b0, take_en = 1'b0, ret_req = 1'b0, rd_ph = 1'b0;
  logic CPU_CLK_STOP, MAIN_CLK_STOP;
  logic [3:0] VEC_SLOT, PROGRAM_STATUS_WORD, RETURN_STATUS_WORD, last_slot;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'hADB78385;
  int num_errors = 0, checks = 0, cyc = 0;

  assign HREADY = HREADYOUT;
  always #10 CLK = ~CLK;

  irq_nest_ctrl irq_nest_ctrl_inst (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .SRC_EVENT(SRC_EVENT), .CPU_ON_SUBCLK(CPU_ON_SUBCLK),
    .VEC_VALID(VEC_VALID), .VEC_SLOT(VEC_SLOT), .VEC_TAKE(VEC_TAKE),
    .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD),
    .RETURN_FROM_IRQ(RETURN_FROM_IRQ),
    .RETURN_STATUS_WORD(RETURN_STATUS_WORD),
    .ANY_REQUEST(ANY_REQUEST), .CPU_CLK_STOP(CPU_CLK_STOP),
    .MAIN_CLK_STOP(MAIN_CLK_STOP));
  cpu_seq_model cpu_seq_model_inst (.CLK(CLK), .RESETN(RESETN),
    .VEC_VALID(VEC_VALID), .VEC_SLOT(VEC_SLOT),
    .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD),
    .take_en(take_en), .ret_req(ret_req), .VEC_TAKE(VEC_TAKE),
    .RETURN_FROM_IRQ(RETURN_FROM_IRQ),
    .RETURN_STATUS_WORD(RETURN_STATUS_WORD), .last_slot(last_slot));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic complete_run;
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  // One single word transfer; the read value is noted for the monitor.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    HSIZE <= 3'h2;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic ev(input int s);
    @(posedge CLK) SRC_EVENT <= NSRC'(1) << s;
    @(posedge CLK) SRC_EVENT <= '0;
    repeat (4) @(posedge CLK);
  endtask : ev

  task automatic ret;
    @(posedge CLK) ret_req <= 1'b1;
    @(posedge CLK) ret_req <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask : ret

  // Lets the sequencer take exactly one vector after a random delay.
  task automatic take_one;
    int n;
    seed = xs(seed);
    repeat (seed[1:0]) @(posedge CLK);
    take_en <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while (VEC_TAKE !== 1'b1 && n < 50);
    if (n >= 50) chk("take", 32'h1, 32'h0);
    @(posedge CLK) take_en <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask : take_one

  task automatic do_reset;
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
  endtask : do_reset

  // ==========================================================================
  // Read monitor and timeout
  // ==========================================================================
  // Read data stands in the data phase and is judged at its closing edge.
  always @(posedge CLK) begin
    if (rd_ph) chk("hrdata", exp_q.pop_front(), HRDATA);
    rd_ph <= HSEL && HTRANS[1] && HREADY && !HWRITE;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    do_reset();
    rd(OFS_REQ_FLAGS, 32'h0);
    rd(OFS_PRIORITY, 32'h0);
    rd(OFS_PROC_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    chk("hresp", 32'h0, HRESP);
    chk("hreadyout", 32'h1, HREADYOUT);
    // Random flags with master enable off: requests raised, none offered.
    seed = xs(seed);
    wr_flags: bus(1'b1, OFS_REQ_FLAGS, {22'h0, seed[9:1], 1'b1});
    rd(OFS_REQ_FLAGS, {22'h0, seed[9:1], 1'b1});
    bus(1'b1, OFS_ENABLES, 32'h3FF);
    bus(1'b1, OFS_PRIORITY, 32'h7);
    chk("any", 32'h1, ANY_REQUEST);
    chk("valid", 32'h0, VEC_VALID);
    bus(1'b1, OFS_PRIORITY, 32'hF);
    rd(OFS_PRIORITY, 32'hF);
    chk("valid", 32'h1, VEC_VALID);
    // Nesting through the status levels with the sequencer always taking.
    do_reset();
    take_en <= 1'b1;
    bus(1'b1, OFS_ENABLES, 32'h3FF);
    bus(1'b1, OFS_PRIORITY, 32'hA);
    ev(SRC_PIN2);
    rd(OFS_PROC_STATUS, 32'h4);
    chk("status_word", 32'h4, PROGRAM_STATUS_WORD);
    chk("slot", 32'h3, last_slot);
    ev(SRC_PIN0);
    chk("valid", 32'h0, VEC_VALID);
    ev(SRC_PIN1);
    rd(OFS_PROC_STATUS, 32'h8);
    chk("slot", 32'h2, last_slot);
    ev(5);
    chk("valid", 32'h0, VEC_VALID);
    ret();
    rd(OFS_PROC_STATUS, 32'h4);
    ret();
    rd(OFS_PROC_STATUS, 32'h4);
    chk("slot", 32'h1, last_slot);
    bus(1'b1, OFS_PRIORITY, 32'h2);
    bus(1'b1, OFS_PROC_STATUS, 32'h0);
    bus(1'b1, OFS_PRIORITY, 32'hA);
    repeat (4) @(posedge CLK);
    rd(OFS_PROC_STATUS, 32'h4);
    chk("slot", 32'h4, last_slot);
    bus(1'b1, OFS_PRIORITY, 32'h2);
    bus(1'b1, OFS_PROC_STATUS, 32'hC);
    rd(OFS_PROC_STATUS, 32'h4);
    // Shared slot with one source enabled, then with both.
    take_en <= 1'b0;
    do_reset();
    bus(1'b1, OFS_PRIORITY, 32'h8);
    bus(1'b1, OFS_ENABLES, 32'h1);
    ev(SRC_TIMER);
    ev(SRC_PIN4);
    take_one();
    chk("slot", 32'h0, last_slot);
    rd(OFS_REQ_FLAGS, 32'h2);
    bus(1'b1, OFS_ENABLES, 32'h3);
    take_one();
    chk("slot", 32'h0, last_slot);
    rd(OFS_REQ_FLAGS, 32'h2);
    bus(1'b1, OFS_PRIORITY, 32'h0);
    rd(OFS_TEST_CLEAR, 32'h2);
    rd(OFS_REQ_FLAGS, 32'h0);
    // Halt and deep stop: entry, live sources and wake-up.
    do_reset();
    bus(1'b1, OFS_ENABLES, 32'hE);
    bus(1'b1, OFS_STANDBY, 32'h1);
    rd(OFS_STANDBY, 32'h1);
    chk("cpu_stop", 32'h1, CPU_CLK_STOP);
    chk("main_stop", 32'h0, MAIN_CLK_STOP);
    ev(SRC_PIN0);
    ev(SRC_TIMER);
    rd(OFS_REQ_FLAGS, 32'h1);
    rd(OFS_STANDBY, 32'h1);
    ev(SRC_PIN1);
    rd(OFS_STANDBY, 32'h0);
    bus(1'b1, OFS_REQ_FLAGS, 32'h0);
    CPU_ON_SUBCLK <= 1'b1;
    bus(1'b1, OFS_STANDBY, 32'h2);
    rd(OFS_STANDBY, 32'h0);
    bus(1'b1, OFS_STANDBY, 32'h3);
    rd(OFS_STANDBY, 32'h1);
    ev(SRC_PIN1);
    rd(OFS_STANDBY, 32'h0);
    chk("cpu_stop", 32'h0, CPU_CLK_STOP);
    bus(1'b1, OFS_REQ_FLAGS, 32'h0);
    CPU_ON_SUBCLK <= 1'b0;
    bus(1'b1, OFS_STANDBY, 32'h2);
    rd(OFS_STANDBY, 32'h2);
    chk("main_stop", 32'h1, MAIN_CLK_STOP);
    ev(SRC_TIMER);
    rd(OFS_REQ_FLAGS, 32'h0);
    ev(SRC_PIN4);
    rd(OFS_STANDBY, 32'h0);
    repeat (2) @(posedge CLK);
    complete_run();
  end
endmodule : nested_interrupt_status_control_tb
